// File: inc/rtcr_pkg.sv
// Package for the clock control/status block: bus map, bit positions, reset values.
// Assumes both ends run on the same 10 MHz reference clock.
`default_nettype none
package rtcr_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam int PER_N = 6;
  // Device bus addresses
  localparam logic [4:0] ADDR_MAIN = 5'h00;
  localparam logic [4:0] ADDR_FLAGS = 5'h03;
  localparam logic [4:0] ADDR_TSAVE = 5'h04;
  localparam logic [4:0] ADDR_MODE = 5'h01;
  localparam logic [4:0] ADDR_OUTSEL = 5'h02;
  localparam logic [4:0] ADDR_PIE = 5'h03;
  // Main status bits
  localparam int MS_IRQ = 0;
  localparam int MS_PF = 1;
  localparam int MS_PER = 2;
  localparam int MS_ALM = 3;
  localparam int MS_BANK = 6;
  localparam logic [7:0] MS_RAM_MASK = 8'hb0;
  // Periodic flag register bits
  localparam int FL_OSC = 6;
  localparam int FL_TEST = 7;
  // Time save control bits
  localparam int TS_EN = 7;
  localparam int TS_NA = 6;
  // Clock mode bits
  localparam int MD_LEAP_LO = 0;
  localparam int MD_12H = 2;
  localparam int MD_RUN = 3;
  localparam int MD_STBY = 4;
  localparam logic [1:0] LEAP_CURRENT = 2'h0;
  localparam logic [1:0] LEAP_STEP = 2'h1;
  // Output select bit
  localparam int OS_SRC = 7;
  // Pin synchroniser lanes
  localparam int PIN_PF = 0;
  localparam int PIN_OSC = 1;
  localparam logic [1:0] PIN_RESET = 2'h1;
  // Host-side software registers
  localparam int HADDR_W = 2;
  localparam int HDATA_W = 16;
  localparam logic [1:0] HREG_CMD = 2'h0;
  localparam logic [1:0] HREG_STAT = 2'h1;
  localparam int HCMD_ADDR_LO = 8;
  localparam int HCMD_READ = 13;
  localparam int HST_BUSY = 8;
  localparam int HST_INTERRUPT_REQUEST_PIN = 9;
  typedef enum logic [1:0] {H_IDLE, H_ISSUE, H_CAPTURE} rtcr_host_state_type;
endpackage
`default_nettype wire

// File: inc/rtcr_if.sv
// Parallel bus and interrupt request pin between the host and the clock device.
// Assumes one shared clock; the open-drain request pin is resolved here with a pull-up.
`default_nettype none
interface rtcr_if;
  logic [4:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic interrupt_request_pin_oe;
  logic interrupt_request_pin_level;
  // Pulled high unless the device sinks it
  assign interrupt_request_pin_level = ~interrupt_request_pin_oe;
  modport dev (
    input addr,
    input wdata,
    input wr,
    input rd,
    output rdata,
    output interrupt_request_pin_oe
  );
  modport host (
    output addr,
    output wdata,
    output wr,
    output rd,
    input rdata,
    input interrupt_request_pin_level
  );
endinterface
`default_nettype wire

// File: rtl/rtcr_device.sv
// Control and status registers of the real time clock device end.
// Assumes counter chain, alarm and supply logic supply single-cycle events on ref_clk_i.
//
// Chosen here: the plain strobed port.
`default_nettype none
module rtcr_device
  import rtcr_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  rtcr_if.dev bus,
  input wire logic power_fail_input_b_i,
  input wire logic osc_clk_i,
  input wire logic [5:0] rollover_i,
  input wire logic alarm_event_i,
  input wire logic year_end_i,
  input wire logic osc_fail_i,
  input wire logic osc_running_i,
  input wire logic standby_i,
  input wire logic alarm_irq_en_i,
  input wire logic power_fail_irq_en_i,
  output logic multi_function_output_o,
  output logic multi_function_output_oe_o,
  output logic clock_run_o,
  output logic twelve_hour_o,
  output logic [1:0] leap_count_o,
  output logic leap_day_en_o,
  output logic time_save_track_o,
  output logic single_supply_o,
  output logic test_mode_en_o,
  output logic alarm_pf_enables_clear_o
);
  logic [1:0] sync_a_r, sync_b_r, sync_c_r, pin_r;
  logic [1:0] pin_nxt;
  logic [7:0] ms_r, ms_nxt;
  logic [5:0] flags_r, flags_nxt;
  logic osc_fail_r, osc_fail_nxt;
  logic single_r, single_nxt;
  logic test_r, test_nxt;
  logic [7:0] tsc_r, tsc_nxt;
  logic [7:0] mode_r, mode_nxt;
  logic [7:0] outsel_r, outsel_nxt;
  logic [7:0] pie_r, pie_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic stby_prev_r;
  logic clr_r, clr_nxt;
  logic interrupt_request_pin_oe_r, interrupt_request_pin_oe_nxt;
  logic mfo_r, mfo_nxt;
  logic mfo_oe_r, mfo_oe_nxt;
  logic bank;
  logic wr_main, wr_flags, wr_tsave, wr_mode, wr_outsel, wr_pie, rd_flags;
  logic stby_rise, per_hit, interrupt_request_pin_pend, mfo_pend;

  // Bank-switched decode; main status ignores the bank
  always_comb begin
    bank = ms_r[MS_BANK];
    wr_main = bus.wr && (bus.addr == ADDR_MAIN);
    wr_flags = 1'b0;
    wr_tsave = 1'b0;
    wr_mode = 1'b0;
    wr_outsel = 1'b0;
    wr_pie = 1'b0;
    rd_flags = 1'b0;
    if (!bank) begin
      wr_flags = bus.wr && (bus.addr == ADDR_FLAGS);
      wr_tsave = bus.wr && (bus.addr == ADDR_TSAVE);
      rd_flags = bus.rd && (bus.addr == ADDR_FLAGS);
    end else begin
      wr_mode = bus.wr && (bus.addr == ADDR_MODE);
      wr_outsel = bus.wr && (bus.addr == ADDR_OUTSEL);
      wr_pie = bus.wr && (bus.addr == ADDR_PIE);
    end
    stby_rise = standby_i && !stby_prev_r;
    per_hit = |(rollover_i & pie_r[PER_N-1:0]);
  end

  // Three-stage pin synchroniser; a change counts once stages two and three agree
  for (genvar g = 0; g < 2; g++) begin : g_pin_lane
    assign pin_nxt[g] = (sync_b_r[g] == sync_c_r[g]) ? sync_c_r[g] : pin_r[g];
  end

  // Main status
  always_comb begin
    ms_nxt = ms_r;
    if (wr_main) begin
      ms_nxt = (ms_r & ~MS_RAM_MASK) | (bus.wdata & MS_RAM_MASK);
      ms_nxt[MS_BANK] = bus.wdata[MS_BANK];
      if (bus.wdata[MS_PER]) begin
        ms_nxt[MS_PER] = 1'b0;
      end
      if (bus.wdata[MS_ALM]) begin
        ms_nxt[MS_ALM] = 1'b0;
      end
    end
    // Events win over a same-cycle clear
    if (per_hit) begin
      ms_nxt[MS_PER] = 1'b1;
    end
    if (alarm_event_i) begin
      ms_nxt[MS_ALM] = 1'b1;
    end
    ms_nxt[MS_PF] = ~pin_r[PIN_PF];
    ms_nxt[MS_IRQ] = 1'b0;
  end

  // Pin drives and summary bit
  always_comb begin
    mfo_pend = !outsel_r[OS_SRC] && ms_r[MS_PF] && power_fail_irq_en_i;
    interrupt_request_pin_pend = ms_r[MS_PER] || (ms_r[MS_ALM] && alarm_irq_en_i)
      || (outsel_r[OS_SRC] && ms_r[MS_PF] && power_fail_irq_en_i);
    interrupt_request_pin_oe_nxt = interrupt_request_pin_pend;
    if (outsel_r[OS_SRC]) begin
      mfo_nxt = pin_r[PIN_OSC];
      mfo_oe_nxt = 1'b1;
    end else begin
      mfo_nxt = 1'b0;
      mfo_oe_nxt = mfo_pend;
    end
  end

  // Periodic flags, supply select, test mode
  always_comb begin
    flags_nxt = flags_r;
    if (rd_flags) begin
      flags_nxt = '0;
    end
    flags_nxt = flags_nxt | rollover_i;
    osc_fail_nxt = osc_fail_r;
    if (wr_mode && bus.wdata[MD_RUN] && osc_running_i) begin
      osc_fail_nxt = 1'b0;
    end
    if (osc_fail_i) begin
      osc_fail_nxt = 1'b1;
    end
    single_nxt = single_r;
    test_nxt = test_r;
    if (wr_flags) begin
      single_nxt = bus.wdata[FL_OSC];
      test_nxt = bus.wdata[FL_TEST];
    end
    if (osc_fail_i) begin
      single_nxt = 1'b1;
    end
  end

  // Time save, mode, output select, periodic enables
  always_comb begin
    tsc_nxt = tsc_r;
    if (wr_tsave) begin
      tsc_nxt = bus.wdata;
      tsc_nxt[TS_NA] = 1'b0;
    end
    if (stby_rise) begin
      tsc_nxt[TS_EN] = 1'b0;
    end
    mode_nxt = mode_r;
    if (year_end_i) begin
      mode_nxt[MD_LEAP_LO +: 2] = mode_r[MD_LEAP_LO +: 2] + LEAP_STEP;
    end
    if (wr_mode) begin
      mode_nxt = bus.wdata;
      mode_nxt[MD_RUN] = bus.wdata[MD_RUN] && osc_running_i;
    end
    if (osc_fail_i) begin
      mode_nxt[MD_RUN] = 1'b0;
    end
    outsel_nxt = wr_outsel ? bus.wdata : outsel_r;
    pie_nxt = wr_pie ? bus.wdata : pie_r;
    clr_nxt = 1'b0;
    if (stby_rise && !mode_r[MD_STBY]) begin
      pie_nxt[PER_N-1:0] = '0;
      clr_nxt = 1'b1;
    end
  end

  // Read data, valid the cycle after the read strobe
  always_comb begin
    rdata_nxt = '0;
    if (bus.rd) begin
      if (bus.addr == ADDR_MAIN) begin
        rdata_nxt = ms_r;
        rdata_nxt[MS_IRQ] = interrupt_request_pin_pend || mfo_pend;
      end else if (!bank && bus.addr == ADDR_FLAGS) begin
        rdata_nxt = {test_r, osc_fail_r, flags_r};
      end else if (!bank && bus.addr == ADDR_TSAVE) begin
        rdata_nxt = tsc_r;
      end else if (bank && bus.addr == ADDR_MODE) begin
        rdata_nxt = mode_r;
      end else if (bank && bus.addr == ADDR_OUTSEL) begin
        rdata_nxt = outsel_r;
      end else if (bank && bus.addr == ADDR_PIE) begin
        rdata_nxt = pie_r;
      end else begin
        rdata_nxt = '0;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      sync_a_r <= PIN_RESET;
      sync_b_r <= PIN_RESET;
      sync_c_r <= PIN_RESET;
      pin_r <= PIN_RESET;
      ms_r <= '0;
      flags_r <= '0;
      osc_fail_r <= 1'b1;
      single_r <= 1'b1;
      test_r <= 1'b0;
      tsc_r <= '0;
      mode_r <= '0;
      outsel_r <= '0;
      pie_r <= '0;
      rdata_r <= '0;
      stby_prev_r <= 1'b0;
      clr_r <= 1'b0;
      interrupt_request_pin_oe_r <= 1'b0;
      mfo_r <= 1'b0;
      mfo_oe_r <= 1'b0;
    end else begin
      sync_a_r <= {osc_clk_i, power_fail_input_b_i};
      sync_b_r <= sync_a_r;
      sync_c_r <= sync_b_r;
      pin_r <= pin_nxt;
      ms_r <= ms_nxt;
      flags_r <= flags_nxt;
      osc_fail_r <= osc_fail_nxt;
      single_r <= single_nxt;
      test_r <= test_nxt;
      tsc_r <= tsc_nxt;
      mode_r <= mode_nxt;
      outsel_r <= outsel_nxt;
      pie_r <= pie_nxt;
      rdata_r <= rdata_nxt;
      stby_prev_r <= standby_i;
      clr_r <= clr_nxt;
      interrupt_request_pin_oe_r <= interrupt_request_pin_oe_nxt;
      mfo_r <= mfo_nxt;
      mfo_oe_r <= mfo_oe_nxt;
    end
  end

  assign bus.rdata = rdata_r;
  assign bus.interrupt_request_pin_oe = interrupt_request_pin_oe_r;
  assign multi_function_output_o = mfo_r;
  assign multi_function_output_oe_o = mfo_oe_r;
  assign clock_run_o = mode_r[MD_RUN];
  assign twelve_hour_o = mode_r[MD_12H];
  assign leap_count_o = mode_r[MD_LEAP_LO +: 2];
  assign leap_day_en_o = (mode_r[MD_LEAP_LO +: 2] == LEAP_CURRENT);
  assign time_save_track_o = tsc_r[TS_EN];
  assign single_supply_o = single_r;
  assign test_mode_en_o = test_r;
  assign alarm_pf_enables_clear_o = clr_r;
endmodule // rtcr_device
`default_nettype wire

// File: rtl/rtcr_host.sv
// Host end: turns software commands into single bus cycles on the clock device.
// Assumes software on the same clock uses the plain strobe port below.
`default_nettype none
module rtcr_host
  import rtcr_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  rtcr_if.host bus,
  input wire logic [1:0] sw_addr_i,
  input wire logic [15:0] sw_wdata_i,
  input wire logic sw_wr_i,
  input wire logic sw_rd_i,
  output logic [15:0] sw_rdata_o
);
  rtcr_host_state_type state_r, state_nxt;
  logic [4:0] addr_r, addr_nxt;
  logic [7:0] wdata_r, wdata_nxt;
  logic wr_r, wr_nxt, rd_r, rd_nxt;
  logic is_read_r, is_read_nxt;
  logic [7:0] result_r, result_nxt;
  logic [15:0] sw_rdata_r, sw_rdata_nxt;
  logic start;

  always_comb begin
    start = sw_wr_i && (sw_addr_i == HREG_CMD) && (state_r == H_IDLE);
    state_nxt = state_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    is_read_nxt = is_read_r;
    result_nxt = result_r;
    wr_nxt = 1'b0;
    rd_nxt = 1'b0;
    case (state_r)
      H_IDLE: begin
        if (start) begin
          // Software writes to clear D2/D3 and to set mode bits pass straight through
          addr_nxt = sw_wdata_i[HCMD_ADDR_LO +: 5];
          wdata_nxt = sw_wdata_i[7:0];
          is_read_nxt = sw_wdata_i[HCMD_READ];
          wr_nxt = !sw_wdata_i[HCMD_READ];
          rd_nxt = sw_wdata_i[HCMD_READ];
          state_nxt = H_ISSUE;
        end
      end
      H_ISSUE: begin
        state_nxt = is_read_r ? H_CAPTURE : H_IDLE;
      end
      H_CAPTURE: begin
        result_nxt = bus.rdata;
        state_nxt = H_IDLE;
      end
      default: begin
        state_nxt = H_IDLE;
      end
    endcase
    sw_rdata_nxt = '0;
    if (sw_rd_i) begin
      if (sw_addr_i == HREG_CMD) begin
        sw_rdata_nxt = {2'h0, is_read_r, addr_r, wdata_r};
      end else if (sw_addr_i == HREG_STAT) begin
        sw_rdata_nxt = {6'h00, ~bus.interrupt_request_pin_level, state_r != H_IDLE, result_r};
      end else begin
        sw_rdata_nxt = '0;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      state_r <= H_IDLE;
      addr_r <= '0;
      wdata_r <= '0;
      is_read_r <= 1'b0;
      result_r <= '0;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      sw_rdata_r <= '0;
    end else begin
      state_r <= state_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      is_read_r <= is_read_nxt;
      result_r <= result_nxt;
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      sw_rdata_r <= sw_rdata_nxt;
    end
  end

  assign bus.addr = addr_r;
  assign bus.wdata = wdata_r;
  assign bus.wr = wr_r;
  assign bus.rd = rd_r;
  assign sw_rdata_o = sw_rdata_r;
endmodule // rtcr_host
`default_nettype wire

// File: tb/rtcr_monitor.sv
// Concurrent checks on the bus between host end and device end.
// Assumes one clock and an active low synchronous reset.
`default_nettype none
module rtcr_monitor
  import rtcr_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic [4:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic bank_r;
  logic bank_nxt;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  // Tracks which register bank the low addresses reach
  always_comb begin
    bank_nxt = bank_r;
    if (wr_i && addr_i == ADDR_MAIN) bank_nxt = wdata_i[MS_BANK];
  end
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) bank_r <= 1'b0;
    else bank_r <= bank_nxt;
  end
  // A write and the next read of the same place, one idle cycle apart
  sequence wr_then_rd(logic [4:0] a, logic b);
    wr_i && addr_i == a && bank_r == b ##2 rd_i && addr_i == a;
  endsequence
  a_strobe_excl:
    assert property (!(wr_i && rd_i)) else $error("wr and rd together");
  a_wr_single_pulse:
    assert property (wr_i |=> !wr_i) else $error("wr held over one cycle");
  a_rdata_idle_zero:
    assert property (!rd_i |=> rdata_i == 8'h00) else $error("rdata not zero");
  a_main_any_bank:
    assert property (rd_i && addr_i == ADDR_MAIN |=> rdata_i[MS_BANK] == bank_r)
    else $error("bank bit misread");
  a_main_ram_store:
    assert property (wr_then_rd(ADDR_MAIN, bank_r) |=>
      (rdata_i & 8'hf0) == ($past(wdata_i, 3) & 8'hf0)) else $error("main bits lost");
  a_tsave_store:
    assert property (wr_then_rd(ADDR_TSAVE, 1'b0) |=>
      rdata_i[6:0] == {1'b0, $past(wdata_i[5:0], 3)}) else $error("time save bits wrong");
  a_outsel_store:
    assert property (wr_then_rd(ADDR_OUTSEL, 1'b1) |=> rdata_i == $past(wdata_i, 3))
    else $error("output select bits lost");
  a_pie_ram_store:
    assert property (wr_then_rd(ADDR_PIE, 1'b1) |=>
      rdata_i[7:6] == $past(wdata_i[7:6], 3)) else $error("enable bits 7:6 lost");
  a_unmapped_zero:
    assert property (rd_i && (addr_i > 5'h04 || (!bank_r && addr_i inside {5'h01, 5'h02}))
      |=> rdata_i == 8'h00) else $error("unmapped read not zero");
endmodule // rtcr_monitor
`default_nettype wire

// File: tb/rtcr_tb.sv
// Bench for the host end and device end joined over the shared bus.
// Assumes a 10 MHz clock and software access through the host command port.
`default_nettype none
module rtcr_tb
  import rtcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic power_fail_input_b_i = 1'b1;
  logic osc_clk_i = 1'b0;
  logic osc_running_i = 1'b0;
  logic standby_i = 1'b0;
  logic [8:0] ev_r = 9'h000;
  logic [1:0] sw_addr_i = 2'h0;
  logic [15:0] sw_wdata_i = 16'h0000;
  logic sw_wr_i = 1'b0;
  logic sw_rd_i = 1'b0;
  logic [15:0] sw_rdata_o;
  logic clock_run_o, twelve_hour_o, leap_day_en_o, time_save_track_o;
  logic single_supply_o, test_mode_en_o, clr_o;
  logic alarm_irq_en_i = 1'b0;
  logic power_fail_irq_en_i = 1'b0;
  logic mfo_o, mfo_oe_o;
  logic [1:0] leap_count_o;
  logic clr_seen = 1'b0;
  logic [15:0] cyc = 16'h0000;
  int err_count = 0;
  int compares = 0;
  always #50 ref_clk_i = ~ref_clk_i;
  rtcr_if bus_if();
  rtcr_device u_rtcr_device (
    .ref_clk_i,
    .rst_b_i,
    .bus(bus_if),
    .power_fail_input_b_i,
    .osc_clk_i,
    .rollover_i(ev_r[5:0]),
    .alarm_event_i(ev_r[6]),
    .year_end_i(ev_r[7]),
    .osc_fail_i(ev_r[8]),
    .osc_running_i,
    .standby_i,
    .alarm_irq_en_i,
    .power_fail_irq_en_i,
    .multi_function_output_o(mfo_o),
    .multi_function_output_oe_o(mfo_oe_o),
    .clock_run_o,
    .twelve_hour_o,
    .leap_count_o,
    .leap_day_en_o,
    .time_save_track_o,
    .single_supply_o,
    .test_mode_en_o,
    .alarm_pf_enables_clear_o(clr_o)
  );
  rtcr_host u_rtcr_host (.ref_clk_i, .rst_b_i, .bus(bus_if), .sw_addr_i, .sw_wdata_i,
    .sw_wr_i, .sw_rd_i, .sw_rdata_o);
  rtcr_monitor u_rtcr_monitor (.ref_clk_i, .rst_b_i, .addr_i(bus_if.addr),
    .wdata_i(bus_if.wdata), .wr_i(bus_if.wr), .rd_i(bus_if.rd), .rdata_i(bus_if.rdata));
  task automatic tally_and_finish();
    if (err_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic sw_write(input logic [1:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    sw_addr_i <= a;
    sw_wdata_i <= d;
    sw_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    sw_wr_i <= 1'b0;
  endtask
  task automatic sw_read(input logic [1:0] a, output logic [15:0] d);
    @(posedge ref_clk_i);
    sw_addr_i <= a;
    sw_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    sw_rd_i <= 1'b0;
    // Read data stand in the cycle after the strobe; take them at its closing edge
    @(posedge ref_clk_i);
    d = sw_rdata_o;
  endtask
  task automatic dev_write(input logic [4:0] a, input logic [7:0] d);
    sw_write(HREG_CMD, {3'h0, a, d});
  endtask
  // Device read through the host, polling busy under a bound
  task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
    logic [15:0] s;
    sw_write(HREG_CMD, {2'h0, 1'b1, a, 8'h00});
    s = 16'hffff;
    for (int i = 0; i < 8 && s[HST_BUSY] !== 1'b0; i++) sw_read(HREG_STAT, s);
    check({s[HST_BUSY], s[7:0]}, {1'b0, e});
  endtask
  task automatic ev(input logic [8:0] v);
    @(posedge ref_clk_i);
    ev_r <= v;
    @(posedge ref_clk_i);
    ev_r <= 9'h000;
    // Let the event's effect settle before the caller looks at outputs
    @(posedge ref_clk_i);
  endtask
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 16'h0001;
    osc_clk_i <= cyc[2];
    if (clr_o === 1'b1) clr_seen <= 1'b1;
    if (cyc == 16'h1388) begin
      err_count++;
      tally_and_finish();
    end
  end
  initial begin
    logic [15:0] s;
    repeat (6) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    check(single_supply_o, 1'b1);
    rd_chk(ADDR_FLAGS, 8'h40);
    rd_chk(5'h01, 8'h00);
    rd_chk(5'h0a, 8'h00);
    dev_write(ADDR_MAIN, 8'hb0);
    rd_chk(ADDR_MAIN, 8'hb0);
    dev_write(ADDR_TSAVE, 8'hff);
    rd_chk(ADDR_TSAVE, 8'hbf);
    check(time_save_track_o, 1'b1);
    dev_write(ADDR_FLAGS, 8'h80);
    repeat (2) @(posedge ref_clk_i);
    check({test_mode_en_o, single_supply_o}, 2'h2);
    rd_chk(ADDR_FLAGS, 8'hc0);
    dev_write(ADDR_FLAGS, 8'h40);
    repeat (2) @(posedge ref_clk_i);
    check({test_mode_en_o, single_supply_o}, 2'h1);
    dev_write(ADDR_MAIN, 8'h40);
    rd_chk(ADDR_MAIN, 8'h40);
    dev_write(ADDR_OUTSEL, 8'h7f);
    rd_chk(ADDR_OUTSEL, 8'h7f);
    dev_write(ADDR_MODE, 8'h0e);
    rd_chk(ADDR_MODE, 8'h06);
    check({clock_run_o, twelve_hour_o, leap_count_o}, 4'h6);
    osc_running_i <= 1'b1;
    dev_write(ADDR_MODE, 8'h0e);
    ev(9'h080);
    check({clock_run_o, leap_count_o}, 3'h7);
    ev(9'h080);
    check({leap_count_o, leap_day_en_o}, 3'h1);
    rd_chk(ADDR_MODE, 8'h0c);
    dev_write(ADDR_PIE, 8'hc4);
    rd_chk(ADDR_PIE, 8'hc4);
    dev_write(ADDR_MAIN, 8'h00);
    rd_chk(ADDR_FLAGS, 8'h00);
    ev(9'h003);
    rd_chk(ADDR_MAIN, 8'h00);
    rd_chk(ADDR_FLAGS, 8'h03);
    rd_chk(ADDR_FLAGS, 8'h00);
    ev(9'h004);
    rd_chk(ADDR_MAIN, 8'h05);
    sw_read(HREG_STAT, s);
    check(s[HST_INTERRUPT_REQUEST_PIN], 1'b1);
    rd_chk(ADDR_MAIN, 8'h05);
    dev_write(ADDR_MAIN, 8'h04);
    rd_chk(ADDR_MAIN, 8'h00);
    ev(9'h040);
    rd_chk(ADDR_MAIN, 8'h08);
    alarm_irq_en_i <= 1'b1;
    rd_chk(ADDR_MAIN, 8'h09);
    dev_write(ADDR_MAIN, 8'h08);
    rd_chk(ADDR_MAIN, 8'h00);
    power_fail_input_b_i <= 1'b0;
    repeat (6) @(posedge ref_clk_i);
    rd_chk(ADDR_MAIN, 8'h02);
    dev_write(ADDR_MAIN, 8'h02);
    rd_chk(ADDR_MAIN, 8'h02);
    power_fail_irq_en_i <= 1'b1;
    rd_chk(ADDR_MAIN, 8'h03);
    check({mfo_oe_o, mfo_o}, 2'h2);
    power_fail_input_b_i <= 1'b1;
    repeat (6) @(posedge ref_clk_i);
    rd_chk(ADDR_MAIN, 8'h00);
    check({mfo_oe_o, mfo_o}, 2'h0);
    ev(9'h100);
    check(clock_run_o, 1'b0);
    rd_chk(ADDR_FLAGS, 8'h44);
    standby_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    check({time_save_track_o, clr_seen}, 2'h1);
    dev_write(ADDR_MAIN, 8'h40);
    rd_chk(ADDR_PIE, 8'hc0);
    standby_i <= 1'b0;
    dev_write(ADDR_MODE, 8'h10);
    dev_write(ADDR_PIE, 8'h3f);
    standby_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    rd_chk(ADDR_PIE, 8'h3f);
    dev_write(ADDR_OUTSEL, 8'h80);
    repeat (8) @(posedge ref_clk_i);
    // Oscillator input flips every four cycles, so the output must too
    s[0] = mfo_o;
    repeat (4) @(posedge ref_clk_i);
    check({mfo_oe_o, mfo_o}, {1'b1, ~s[0]});
    tally_and_finish();
  end
endmodule // rtcr_tb
`default_nettype wire
